// >>> core/pmsmi_regs.vh
// constants of the power-management interrupt and clock-control block
`ifndef PMSMI_REGS_VH
`define PMSMI_REGS_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PMSMI_CLK_PERIOD_NS    36'h0_0000_000A
`define PMSMI_MINUTE_NS        36'hD_F847_5800
`define PMSMI_MINUTE_CYCLES    (`PMSMI_MINUTE_NS / `PMSMI_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// sm_event_enable / sm_request_status bit positions
// ----------------------------------------------------------------
`define PMSMI_SRC_IRQ1         3'h0
`define PMSMI_SRC_IRQ3         3'h1
`define PMSMI_SRC_IRQ4         3'h2
`define PMSMI_SRC_IRQ8         3'h3
`define PMSMI_SRC_IRQ12        3'h4
`define PMSMI_SRC_IDLE         3'h5
`define PMSMI_SRC_EXT          3'h6
`define PMSMI_SRC_SW           3'h7

// ----------------------------------------------------------------
// system_event_enable bit positions above the irq lines (15:0)
// ----------------------------------------------------------------
`define PMSMI_SEE_NMI          5'h10
`define PMSMI_SEE_SMI          5'h11
`define PMSMI_SEE_PERIPH       5'h12
`define PMSMI_SEE_DMA          5'h13

// ----------------------------------------------------------------
// i/o addresses of the power command and status ports
// ----------------------------------------------------------------
`define PMSMI_CMD_PORT         16'h00B2
`define PMSMI_STS_PORT         16'h00B3

// ----------------------------------------------------------------
// peripheral ranges that count as activity
// ----------------------------------------------------------------
`define PMSMI_IDE2_LO          16'h0170
`define PMSMI_IDE2_HI          16'h017F
`define PMSMI_IDE1_LO          16'h01F0
`define PMSMI_IDE1_HI          16'h01FF
`define PMSMI_LPT3_LO          16'h0278
`define PMSMI_LPT3_HI          16'h027F
`define PMSMI_COM4_LO          16'h02E8
`define PMSMI_COM4_HI          16'h02EF
`define PMSMI_COM2_LO          16'h02F8
`define PMSMI_COM2_HI          16'h02FF
`define PMSMI_IDE3_LO          16'h0320
`define PMSMI_IDE3_HI          16'h032F
`define PMSMI_FLP2_LO          16'h0370
`define PMSMI_FLP2_HI          16'h0377
`define PMSMI_LPT2_LO          16'h0378
`define PMSMI_LPT2_HI          16'h037F
`define PMSMI_LPT1_LO          16'h03BC
`define PMSMI_LPT1_HI          16'h03BF
`define PMSMI_COM3_LO          16'h03E8
`define PMSMI_COM3_HI          16'h03EF
`define PMSMI_FLP1_LO          16'h03F0
`define PMSMI_FLP1_HI          16'h03F7
`define PMSMI_COM1_LO          16'h03F8
`define PMSMI_COM1_HI          16'h03FF

// ----------------------------------------------------------------
// dma register ranges that count as activity
// ----------------------------------------------------------------
`define PMSMI_DMA1_LO          16'h0000
`define PMSMI_DMA1_HI          16'h000F
`define PMSMI_DMAP_LO          16'h0080
`define PMSMI_DMAP_HI          16'h008F
`define PMSMI_DMA2_LO          16'h00C0
`define PMSMI_DMA2_HI          16'h00DE
`define PMSMI_DMAX_LO          16'h0400
`define PMSMI_DMAX_HI          16'h043F
`define PMSMI_DMAY_LO          16'h0481
`define PMSMI_DMAY_HI          16'h04FF

`endif

// >>> core/pmsmi_prescaler.v
// minute-rate tick divider for the idle timer
`timescale 1ns/1ps
`include "pmsmi_regs.vh"

module pmsmi_prescaler
#(
   parameter [35:0] MINUTE_CYCLES = `PMSMI_MINUTE_CYCLES
)
(
   input  wire clk_in,   // system clock
   input  wire rst_in,   // async reset, active high
   output reg  tick_out  // one-cycle pulse once a minute
);

   reg [35:0] count_q;

   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         count_q  <= 36'h0_0000_0000;
         tick_out <= 1'b0;
      end
      else if (count_q >= MINUTE_CYCLES - 36'h0_0000_0001)
      begin
         count_q  <= 36'h0_0000_0000;
         tick_out <= 1'b1;
      end
      else
      begin
         count_q  <= count_q + 36'h0_0000_0001;
         tick_out <= 1'b0;
      end
   end

endmodule // pmsmi_prescaler

// >>> core/pmsmi_core.v
// power-management interrupt, idle timer and cpu clock-stop control
//
// Contract
// - in power-on, idle expiry, request pin and os call raise interrupt
// - one enable bit per interrupt source gates its request
// - global enable, when clear, blocks every interrupt assertion
// - status bits record which events requested an interrupt
// - enabled irq 12,8#,4,3,1 and idle expiry interrupt in any power state
// - idle timer counts down from programmed value; zero may interrupt
// - idle timer drops once a minute, reloads on enabled system events
// - irq lines other than irq2, nmi and interrupt output are system events when enabled
// - each system event has an enable; enabled events reload the idle timer
// - peripheral i/o range accesses reload the idle timer
// - dma register range accesses are system events
// - request pin asserts an interrupt when enabled
// - command port write is a software event; status port holds data
// - ports in i/o space, forwarded subtractively, unreachable from isa masters
// - interrupt asserted only while soft-init is negated
// - soft-init seen during an interrupt negates it
// - command port read asserts clock stop when enabled
// - break event after stop grant negates clock stop
// - clock-stop disable or command port write negates clock stop
// - interrupt holds until the handler clears the gate
`timescale 1ns/1ps
`include "pmsmi_regs.vh"

module pmsmi_core
#(
   parameter [35:0] MINUTE_CYCLES = `PMSMI_MINUTE_CYCLES
)
(
   input  wire        clk_in,                 // system clock, 100 MHz
   input  wire        rst_in,                 // async reset, active high
   input  wire [15:0] irq_in,                 // raw irq lines, bit 8 active low
   input  wire        nmi_in,                 // nmi to cpu, active high
   input  wire        external_sm_request_n_in, // external request pin, active low
   input  wire        soft_init_in,           // cpu soft-init, active high
   input  wire        stop_grant_in,          // stop-grant special cycle seen, pulse
   input  wire        io_valid_in,            // i/o access strobe, pulse
   input  wire        io_write_in,            // 1 write, 0 read
   input  wire        io_isa_master_in,       // access started by an isa master
   input  wire [15:0] io_addr_in,             // i/o address
   input  wire [7:0]  io_wdata_in,            // i/o write data
   input  wire [7:0]  sm_event_enable_in,     // per-source interrupt enables
   input  wire        sm_global_enable_in,    // global interrupt enable
   input  wire        clock_stop_enable_in,   // clock-stop enable
   input  wire [19:0] system_event_enable_in, // system/break event enables
   input  wire [7:0]  idle_start_in,          // idle timer start value
   input  wire        idle_load_in,           // load start value, pulse
   input  wire        sm_gate_clear_in,       // handler clears the gate, pulse
   input  wire [7:0]  sm_status_clear_in,     // write-one-to-clear status, pulse
   input  wire        enter_fast_off_in,      // handler enters fast-off, pulse
   output reg         system_mgmt_irq_n_out,  // interrupt to cpu, active low
   output reg         cpu_clock_stop_n_out,   // clock stop to cpu, active low
   output reg  [7:0]  sm_request_status_out,  // sticky source status
   output reg  [7:0]  idle_count_out,         // idle timer value
   output reg         fast_off_out,           // 1 in fast-off state
   output reg  [7:0]  power_command_out,      // last command port byte
   output reg  [7:0]  io_rdata_out,           // read data of the ports
   output reg         io_forward_out          // forward access to isa, pulse
);

   // ----------------------------------------------------------------
   // address decode helpers
   // ----------------------------------------------------------------
   function in_rng;
      input [15:0] a;
      input [15:0] lo;
      input [15:0] hi;
      begin
         in_rng = (a >= lo) && (a <= hi);
      end
   endfunction

   function in_periph;
      input [15:0] a;
      begin
         in_periph = in_rng(a, `PMSMI_IDE2_LO, `PMSMI_IDE2_HI) | in_rng(a, `PMSMI_IDE1_LO, `PMSMI_IDE1_HI)
                   | in_rng(a, `PMSMI_LPT3_LO, `PMSMI_LPT3_HI) | in_rng(a, `PMSMI_COM4_LO, `PMSMI_COM4_HI)
                   | in_rng(a, `PMSMI_COM2_LO, `PMSMI_COM2_HI) | in_rng(a, `PMSMI_IDE3_LO, `PMSMI_IDE3_HI)
                   | in_rng(a, `PMSMI_FLP2_LO, `PMSMI_FLP2_HI) | in_rng(a, `PMSMI_LPT2_LO, `PMSMI_LPT2_HI)
                   | in_rng(a, `PMSMI_LPT1_LO, `PMSMI_LPT1_HI) | in_rng(a, `PMSMI_COM3_LO, `PMSMI_COM3_HI)
                   | in_rng(a, `PMSMI_FLP1_LO, `PMSMI_FLP1_HI) | in_rng(a, `PMSMI_COM1_LO, `PMSMI_COM1_HI);
      end
   endfunction

   function in_dma;
      input [15:0] a;
      begin
         in_dma = in_rng(a, `PMSMI_DMA1_LO, `PMSMI_DMA1_HI) | in_rng(a, `PMSMI_DMAP_LO, `PMSMI_DMAP_HI)
                | in_rng(a, `PMSMI_DMA2_LO, `PMSMI_DMA2_HI) | in_rng(a, `PMSMI_DMAX_LO, `PMSMI_DMAX_HI)
                | in_rng(a, `PMSMI_DMAY_LO, `PMSMI_DMAY_HI);
      end
   endfunction

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   reg  [18:0] sync1_q;
   reg  [18:0] sync2_q;
   reg  [15:0] irq_prev_q;
   reg         ext_prev_q;

   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         sync1_q    <= 19'h0_0000;
         sync2_q    <= 19'h0_0000;
         irq_prev_q <= 16'h0000;
         ext_prev_q <= 1'b0;
      end
      else
      begin
         sync1_q    <= {soft_init_in, ~external_sm_request_n_in, nmi_in, irq_in ^ 16'h0100};
         sync2_q    <= sync1_q;
         irq_prev_q <= sync2_q[15:0];
         ext_prev_q <= sync2_q[17];
      end
   end

   // irq8 was inverted on entry, so every line is active high from here on
   wire [15:0] irq_lvl  = sync2_q[15:0];
   wire        nmi_lvl  = sync2_q[16];
   wire        ext_lvl  = sync2_q[17];
   wire        init_lvl = sync2_q[18];
   wire [15:0] irq_rise = irq_lvl & ~irq_prev_q;

   // ----------------------------------------------------------------
   // i/o port decode
   // ----------------------------------------------------------------
   // isa masters never reach the ports; only host-side accesses count
   wire host_io   = io_valid_in & ~io_isa_master_in;
   wire cmd_hit   = host_io & (io_addr_in == `PMSMI_CMD_PORT);
   wire sts_hit   = host_io & (io_addr_in == `PMSMI_STS_PORT);
   wire cmd_write = cmd_hit & io_write_in;
   wire cmd_read  = cmd_hit & ~io_write_in;
   wire sts_write = sts_hit & io_write_in;
   reg  [7:0] power_status_q;

   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         power_command_out <= 8'h00;
         power_status_q    <= 8'h00;
         io_rdata_out      <= 8'h00;
         io_forward_out    <= 1'b0;
      end
      else
      begin
         io_forward_out <= cmd_hit | sts_hit;
         if (cmd_write)
            power_command_out <= io_wdata_in;
         if (sts_write)
            power_status_q <= io_wdata_in;
         if (cmd_read)
            io_rdata_out <= power_command_out;
         else if (sts_hit & ~io_write_in)
            io_rdata_out <= power_status_q;
      end
   end

   // ----------------------------------------------------------------
   // system and break events
   // ----------------------------------------------------------------
   wire periph_acc = io_valid_in & in_periph(io_addr_in) & system_event_enable_in[`PMSMI_SEE_PERIPH];
   wire dma_acc    = io_valid_in & in_dma(io_addr_in) & system_event_enable_in[`PMSMI_SEE_DMA];
   // irq2 is the cascade input and takes no part
   wire [15:0] irq_ev_mask = 16'hFFFB;
   wire sys_event = |(irq_lvl & irq_ev_mask & system_event_enable_in[15:0])
                  | (nmi_lvl & system_event_enable_in[`PMSMI_SEE_NMI])
                  | (~system_mgmt_irq_n_out & system_event_enable_in[`PMSMI_SEE_SMI])
                  | periph_acc | dma_acc;

   // ----------------------------------------------------------------
   // idle timer
   // ----------------------------------------------------------------
   wire minute_tick;

   pmsmi_prescaler
   #(
      .MINUTE_CYCLES (MINUTE_CYCLES)
   )
   u_prescaler
   (
      .clk_in   (clk_in),
      .rst_in   (rst_in),
      .tick_out (minute_tick)
   );

   reg idle_expire_q;

   // a zero start value never counts down and never expires; software keeps it nonzero
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         idle_count_out <= 8'h00;
         idle_expire_q  <= 1'b0;
      end
      else
      begin
         idle_expire_q <= 1'b0;
         if (idle_load_in | sys_event)
            idle_count_out <= idle_start_in;
         else if (minute_tick && (idle_count_out != 8'h00))
         begin
            idle_count_out <= idle_count_out - 8'h01;
            if (idle_count_out == 8'h01)
               idle_expire_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // interrupt sources and status
   // ----------------------------------------------------------------
   wire [7:0] src_event;
   assign src_event[`PMSMI_SRC_IRQ1]  = irq_rise[1];
   assign src_event[`PMSMI_SRC_IRQ3]  = irq_rise[3];
   assign src_event[`PMSMI_SRC_IRQ4]  = irq_rise[4];
   assign src_event[`PMSMI_SRC_IRQ8]  = irq_rise[8];
   assign src_event[`PMSMI_SRC_IRQ12] = irq_rise[12];
   assign src_event[`PMSMI_SRC_IDLE]  = idle_expire_q;
   assign src_event[`PMSMI_SRC_EXT]   = ext_lvl & ~ext_prev_q;
   assign src_event[`PMSMI_SRC_SW]    = cmd_write;

   wire [7:0] src_req = src_event & sm_event_enable_in;

   reg smi_pend_q;

   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         sm_request_status_out <= 8'h00;
         smi_pend_q            <= 1'b0;
         system_mgmt_irq_n_out <= 1'b1;
      end
      else
      begin
         // a new request in the clearing cycle survives the clear
         sm_request_status_out <= (sm_request_status_out & ~sm_status_clear_in) | src_req;
         if ((|src_req) & sm_global_enable_in)
            smi_pend_q <= 1'b1;
         else if (sm_gate_clear_in)
            smi_pend_q <= 1'b0;
         // init holds the output off; the pending request comes back once init drops
         system_mgmt_irq_n_out <= ~(((|src_req) & sm_global_enable_in | smi_pend_q & ~sm_gate_clear_in)
                                    & ~init_lvl & sm_global_enable_in);
      end
   end

   // ----------------------------------------------------------------
   // power state
   // ----------------------------------------------------------------
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
         fast_off_out <= 1'b0;
      else if (sys_event)
         fast_off_out <= 1'b0;
      else if (enter_fast_off_in)
         fast_off_out <= 1'b1;
   end

   // ----------------------------------------------------------------
   // cpu clock stop
   // ----------------------------------------------------------------
   // the cpu takes clock stop with no acknowledge and stays granted until it is released
   reg grant_seen_q;

   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cpu_clock_stop_n_out <= 1'b1;
         grant_seen_q         <= 1'b0;
      end
      else
      begin
         if (~clock_stop_enable_in | cmd_write)
         begin
            cpu_clock_stop_n_out <= 1'b1;
            grant_seen_q         <= 1'b0;
         end
         else if (sys_event & grant_seen_q)
         begin
            cpu_clock_stop_n_out <= 1'b1;
            grant_seen_q         <= 1'b0;
         end
         else if (cmd_read)
            cpu_clock_stop_n_out <= 1'b0;
         else if (stop_grant_in & ~cpu_clock_stop_n_out)
            grant_seen_q <= 1'b1;
      end
   end

endmodule // pmsmi_core

// >>> testbench/pmsmi_monitor.sv
// assertion checker for the power-management interrupt block
`timescale 1ns/1ps
`include "pmsmi_regs.vh"

module pmsmi_monitor
#(
   parameter [35:0] MINUTE_CYCLES = 36'h0_0000_0014
)
(
   input wire        clk_in,                // clock
   input wire        rst_in,                // reset
   input wire        soft_init_in,          // soft-init
   input wire        io_valid_in,           // access strobe
   input wire        io_write_in,           // write
   input wire        io_isa_master_in,      // isa master
   input wire [15:0] io_addr_in,            // address
   input wire [7:0]  io_wdata_in,           // write data
   input wire [7:0]  sm_event_enable_in,    // source enables
   input wire        sm_global_enable_in,   // global enable
   input wire        clock_stop_enable_in,  // stop enable
   input wire [7:0]  idle_start_in,         // idle start
   input wire        idle_load_in,          // idle load
   input wire        sm_gate_clear_in,      // gate clear
   input wire        system_mgmt_irq_n_out, // interrupt
   input wire        cpu_clock_stop_n_out,  // clock stop
   input wire [7:0]  sm_request_status_out, // status
   input wire [7:0]  idle_count_out,        // idle count
   input wire        io_forward_out,        // forward
   input wire [7:0]  power_command_out      // command byte
);
   wire hit;
   wire cmd_wr;
   wire cmd_rd;
   // isa masters never reach the ports, so they never count as hits
   assign hit    = io_valid_in && !io_isa_master_in &&
                   (io_addr_in == `PMSMI_CMD_PORT || io_addr_in == `PMSMI_STS_PORT);
   assign cmd_wr = hit && io_write_in && io_addr_in == `PMSMI_CMD_PORT;
   assign cmd_rd = hit && !io_write_in && io_addr_in == `PMSMI_CMD_PORT;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   chk_fwd_on_hit: assert property (1'b1 |=> io_forward_out == $past(hit))
      else $error("forward pulse does not follow a port hit");
   chk_isa_ignored: assert property (io_valid_in && io_isa_master_in |=> $stable(power_command_out))
      else $error("isa master access changed the command byte");
   chk_cmd_capture: assert property (cmd_wr |=> power_command_out == $past(io_wdata_in))
      else $error("command byte not captured");
   chk_sw_status: assert property (cmd_wr && sm_event_enable_in[`PMSMI_SRC_SW]
                                   |=> sm_request_status_out[`PMSMI_SRC_SW])
      else $error("software event not recorded");
   chk_init_blocks: assert property (soft_init_in [*4] |-> system_mgmt_irq_n_out)
      else $error("interrupt asserted while soft-init high");
   chk_global_off: assert property (!sm_global_enable_in [*2] |-> system_mgmt_irq_n_out)
      else $error("interrupt asserted with global enable off");
   chk_irq_holds: assert property (!system_mgmt_irq_n_out && !sm_gate_clear_in && sm_global_enable_in &&
                                   !soft_init_in && !$past(soft_init_in) && !$past(soft_init_in, 2)
                                   |=> !system_mgmt_irq_n_out)
      else $error("interrupt dropped before gate clear");
   chk_gate_clear: assert property (sm_gate_clear_in && !cmd_wr |=> system_mgmt_irq_n_out)
      else $error("gate clear did not drop interrupt");
   chk_stop_read: assert property (cmd_rd && clock_stop_enable_in |=> !cpu_clock_stop_n_out)
      else $error("command read did not assert clock stop");
   chk_stop_release: assert property (!clock_stop_enable_in || cmd_wr |=> cpu_clock_stop_n_out)
      else $error("clock stop not released");
   chk_idle_load: assert property (idle_load_in |=> idle_count_out == $past(idle_start_in))
      else $error("idle timer not loaded");
endmodule // pmsmi_monitor

// >>> testbench/pmsmi_cpu_model.sv
// host cpu stand-in: answers clock stop with one stop-grant pulse
`timescale 1ns/1ps

module pmsmi_cpu_model
#(
   parameter GRANT_DELAY = 8
)
(
   input  wire clk_in,              // clock
   input  wire rst_in,              // reset
   input  wire cpu_clock_stop_n_in, // clock stop from device
   input  wire init_req_in,         // bench asks for soft-init
   output reg  soft_init_out,       // soft-init to device
   output reg  stop_grant_out       // stop-grant cycle pulse
);
   integer wait_q;
   always @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         wait_q         <= 0;
         soft_init_out  <= 1'b0;
         stop_grant_out <= 1'b0;
      end
      else
      begin
         soft_init_out  <= init_req_in;
         // no acknowledge cycle; one grant, then stay stopped until negated
         stop_grant_out <= !cpu_clock_stop_n_in && wait_q == GRANT_DELAY - 1;
         if (cpu_clock_stop_n_in)
            wait_q <= 0;
         else if (wait_q < GRANT_DELAY)
            wait_q <= wait_q + 1;
      end
   end
endmodule // pmsmi_cpu_model

// >>> testbench/tb_pmsmi_core.sv
// self-checking bench for the power-management interrupt block
`timescale 1ns/1ps
`include "pmsmi_regs.vh"

module tb_pmsmi_core;
   localparam [35:0] MIN_CYC = 36'h0_0000_0014;
   localparam [19:0] LINES   = 20'hC_8431;
   reg         clk, rst, ext_n, vld, wr, isa, glob, stp, ld, gclr, foff, ireq, nmi;
   reg  [15:0] irq, adr;
   reg  [7:0]  wd, en, ist, sclr;
   reg  [19:0] system_event_enable;
   wire        sinit, sgnt, irq_n, stop_n, fast, fwd;
   wire [7:0]  stat, icnt, pcmd, rdat;
   integer     n_errors, n_checks, i, t0;

   pmsmi_core #(.MINUTE_CYCLES(MIN_CYC)) u_dut (.clk_in(clk), .rst_in(rst), .irq_in(irq), .nmi_in(nmi),
      .external_sm_request_n_in(ext_n), .soft_init_in(sinit), .stop_grant_in(sgnt), .io_valid_in(vld),
      .io_write_in(wr), .io_isa_master_in(isa), .io_addr_in(adr), .io_wdata_in(wd), .sm_event_enable_in(en),
      .sm_global_enable_in(glob), .clock_stop_enable_in(stp), .system_event_enable_in(system_event_enable),
      .idle_start_in(ist), .idle_load_in(ld), .sm_gate_clear_in(gclr), .sm_status_clear_in(sclr),
      .enter_fast_off_in(foff), .system_mgmt_irq_n_out(irq_n), .cpu_clock_stop_n_out(stop_n),
      .sm_request_status_out(stat), .idle_count_out(icnt), .fast_off_out(fast), .power_command_out(pcmd),
      .io_rdata_out(rdat), .io_forward_out(fwd));
   pmsmi_cpu_model u_cpu (.clk_in(clk), .rst_in(rst), .cpu_clock_stop_n_in(stop_n), .init_req_in(ireq),
      .soft_init_out(sinit), .stop_grant_out(sgnt));

   task chk(input [15:0] got, input [15:0] exp);
   begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
         n_errors = n_errors + 1;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   task cyc(input integer n);
   begin
      repeat (n) @(posedge clk);
      #1;
   end
   endtask
   task io(input w, input [15:0] a, input [7:0] d, input m);
   begin
      @(posedge clk);
      vld <= 1'b1;
      wr  <= w;
      adr <= a;
      wd  <= d;
      isa <= m;
      cyc(1);
      vld <= 1'b0;
   end
   endtask
   task clean;
   begin
      @(posedge clk);
      gclr <= 1'b1;
      sclr <= 8'hFF;
      cyc(1);
      gclr <= 1'b0;
      sclr <= 8'h00;
      cyc(1);
   end
   endtask
   task t_sw;
   begin
      @(posedge clk);
      en   <= 8'h80;
      glob <= 1'b1;
      io(1, 16'h00B2, 8'hA5, 0);
      chk(fwd, 1);
      chk(pcmd, 8'hA5);
      chk(stat, 8'h80);
      chk(irq_n, 0);
      cyc(1);
      chk(irq_n, 0);
      clean;
      chk(irq_n, 1);
      io(1, 16'h00B3, 8'h3C, 0);
      io(0, 16'h00B3, 8'h00, 0);
      chk(rdat, 8'h3C);
      io(0, 16'h00B2, 8'h00, 0);
      chk(rdat, 8'hA5);
      chk(stop_n, 1);
      // look in the cycle the forward pulse would stand
      io(1, 16'h00B2, 8'h5A, 1);
      chk(fwd, 0);
      chk(pcmd, 8'hA5);
      glob <= 1'b0;
      io(1, 16'h00B2, 8'h11, 0);
      cyc(3);
      chk(stat, 8'h80);
      chk(irq_n, 1);
      clean;
      en   <= 8'h00;
      glob <= 1'b1;
      io(1, 16'h00B2, 8'h22, 0);
      cyc(3);
      chk(stat, 8'h00);
      chk(irq_n, 1);
   end
   endtask
   task t_hw;
   begin
      foff <= 1'b1;
      cyc(1);
      foff <= 1'b0;
      cyc(1);
      chk(fast, 1);
      for (i = 0; i < 5; i = i + 1)
      begin
         en  <= 8'h01 << i;
         irq <= 16'h0100 ^ (16'h0001 << LINES[4*i +: 4]);
         cyc(6);
         chk(irq_n, 0);
         chk(stat, 8'h01 << i);
         irq <= 16'h0100;
         clean;
      end
      chk(fast, 1);
      system_event_enable <= 20'h0_0002;
      irq <= 16'h0102;
      cyc(6);
      chk(fast, 0);
      // nmi alone as the break event
      irq  <= 16'h0100;
      system_event_enable  <= 20'h1_0000;
      foff <= 1'b1;
      cyc(1);
      foff <= 1'b0;
      chk(fast, 1);
      nmi  <= 1'b1;
      cyc(4);
      chk(fast, 0);
      nmi  <= 1'b0;
      system_event_enable  <= 20'h0_0000;
      en  <= 8'h40;
      ext_n <= 1'b0;
      cyc(6);
      chk(irq_n, 0);
      chk(stat, 8'h40);
      ireq <= 1'b1;
      cyc(6);
      chk(irq_n, 1);
      ireq <= 1'b0;
      cyc(6);
      chk(irq_n, 0);
      ext_n <= 1'b1;
      clean;
   end
   endtask
   task t_idle;
   begin
      en  <= 8'h20;
      ist <= 8'h02; // never zero
      ld  <= 1'b1;
      cyc(1);
      ld  <= 1'b0;
      cyc(1);
      chk(icnt, 2);
      t0 = 0;
      while (irq_n === 1'b1 && t0 < 100)
      begin
         cyc(1);
         t0 = t0 + 1;
      end
      chk(t0 >= 20 && t0 <= 44, 1);
      chk(stat, 8'h20);
      en  <= 8'h00;
      clean;
      system_event_enable <= 20'hC_0000;
      ist <= 8'h03;
      for (i = 0; i < 2; i = i + 1)
      begin
         cyc(41);
         chk(icnt <= 1, 1);
         io(0, i ? 16'h00C0 : 16'h03F8, 8'h00, 0);
         cyc(1);
         chk(icnt >= 2, 1);
      end
      system_event_enable <= 20'h0_0000;
   end
   endtask
   task t_stop;
   begin
      stp <= 1'b1;
      system_event_enable <= 20'h0_0008;
      io(0, 16'h00B2, 8'h00, 0);
      chk(stop_n, 0);
      irq <= 16'h0108;
      cyc(3);
      chk(stop_n, 0);
      cyc(15);
      chk(stop_n, 1);
      irq <= 16'h0100;
      io(0, 16'h00B2, 8'h00, 0);
      stp <= 1'b0;
      cyc(2);
      chk(stop_n, 1);
      stp <= 1'b1;
      io(0, 16'h00B2, 8'h00, 0);
      chk(stop_n, 0);
      io(1, 16'h00B2, 8'h33, 0);
      chk(stop_n, 1);
      stp <= 1'b0;
   end
   endtask
   task end_sim;
   begin
      $display("checks=%0d errors=%0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      #200000;
      n_errors = n_errors + 1;
      end_sim;
   end
   initial
   begin
      n_errors = 0;
      n_checks = 0;
      {rst, ext_n} = 2'b11;
      {vld, wr, isa, glob, stp, ld, gclr, foff, ireq, nmi} = 10'h000;
      irq = 16'h0100;
      {adr, wd, en, ist, sclr, system_event_enable} = 68'h0;
      cyc(12);
      chk({irq_n, stop_n, fast, fwd}, 4'hC);
      chk({stat, icnt}, 16'h0000);
      rst <= 1'b0;
      cyc(3);
      t_sw;
      t_hw;
      t_idle;
      t_stop;
      end_sim;
   end
endmodule // tb_pmsmi_core

bind pmsmi_core pmsmi_monitor #(.MINUTE_CYCLES(MINUTE_CYCLES)) u_mon (.clk_in(clk_in), .rst_in(rst_in),
   .soft_init_in(soft_init_in), .io_valid_in(io_valid_in), .io_write_in(io_write_in),
   .io_isa_master_in(io_isa_master_in), .io_addr_in(io_addr_in), .io_wdata_in(io_wdata_in),
   .sm_event_enable_in(sm_event_enable_in), .sm_global_enable_in(sm_global_enable_in),
   .clock_stop_enable_in(clock_stop_enable_in), .idle_start_in(idle_start_in), .idle_load_in(idle_load_in),
   .sm_gate_clear_in(sm_gate_clear_in), .system_mgmt_irq_n_out(system_mgmt_irq_n_out),
   .cpu_clock_stop_n_out(cpu_clock_stop_n_out), .sm_request_status_out(sm_request_status_out),
   .idle_count_out(idle_count_out), .io_forward_out(io_forward_out), .power_command_out(power_command_out));
